// ==== dcr_bank.sv ====
/*
 * Control register bank of a direct digital synthesizer: buffered register
 * writes, commit on the divided sync clock, phase accumulator, amplitude
 * keying, sync clock alignment and power-down decode.
 * Assumes a serial port front end that hands over whole register words and
 * that all pins are synchronous to clk.
 */
`timescale 1ns/10ps
`include "dcr_defs.svh"

module dcr_bank (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        wr_en,
	input  wire logic [4:0]  wr_addr,
	input  wire logic [31:0] wr_data,
	input  wire logic [4:0]  rd_addr,
	output logic      [31:0] rd_data,
	input  wire logic        io_update,
	input  wire logic        sync_in,
	input  wire logic        keying_input_pin,
	input  wire logic        power_down_pin,
	output logic             sync_clk_out,
	output logic      [13:0] phase_word,
	output logic             sine_sel,
	output logic      [13:0] amp_scale,
	output dcr_pkg::dcr_key_mode_t key_mode,
	output logic             digital_pd,
	output logic             dac_pd,
	output logic             clk_in_pd,
	output logic             pll_pd,
	output logic             sdio_input_only,
	output logic             lsb_first,
	output logic      [4:0]  pll_mult,
	output logic             pll_bypass,
	output logic             vco_range,
	output logic      [1:0]  cp_current,
	output logic             xtal_out_en,
	output logic             hs_sync_en
);
	import dcr_pkg::*;

	dcr_bank_state_t s;
	dcr_bank_state_t next_s;

	logic            sync_edge;
	logic            commit;
	logic            sync_rise;
	logic            adv;
	logic            ramp_load;
	logic [13:0]     ramp_scale;
	logic            auto_now;

	// Derived decode from the committed words
	always_comb begin
		if (!s.main_act[`DCR_B_KEY_EN]) begin
			key_mode = DCR_KEY_OFF;
		end else if (s.main_act[`DCR_B_KEY_AUTO]) begin
			key_mode = DCR_KEY_AUTO;
		end else begin
			key_mode = DCR_KEY_MANUAL;
		end
	end

	// Pin power-down reaches analog sections only in full mode
	assign digital_pd = s.main_act[`DCR_B_DIG_PD] | power_down_pin;
	assign dac_pd     = s.main_act[`DCR_B_DAC_PD]
		| (power_down_pin & s.main_act[`DCR_B_FULL_PD]);
	assign clk_in_pd  = s.main_act[`DCR_B_CLKIN_PD]
		| (power_down_pin & s.main_act[`DCR_B_FULL_PD]);
	assign pll_pd     = power_down_pin & s.main_act[`DCR_B_FULL_PD];

	assign sine_sel        = s.main_act[`DCR_B_SINE];
	assign sdio_input_only = s.main_act[`DCR_B_SDIO_IN];
	assign lsb_first       = s.main_act[`DCR_B_LSB_FIRST];
	assign pll_mult        = s.ana_act[7:3];
	assign pll_bypass      = (s.ana_act[7:3] < `DCR_PLL_MIN)
		|| (s.ana_act[7:3] > `DCR_PLL_MAX);
	assign vco_range       = s.ana_act[`DCR_B_VCO_HI];
	assign cp_current      = s.ana_act[1:0];
	assign xtal_out_en     = s.ana_act[`DCR_B_XTAL_OUT];
	assign hs_sync_en      = s.ana_act[`DCR_B_HS_SYNC];

	// Sync clock keeps running internally even when the pin is held low
	assign sync_clk_out = s.div[1] & ~s.main_act[`DCR_B_SYNC_OFF];
	assign sync_edge    = (s.div == `DCR_SYNC_RISE);
	assign commit       = sync_edge & io_update;
	assign sync_rise    = sync_in & ~s.sync_in_q;

	assign phase_word = s.phase;
	assign amp_scale  = s.amp;
	assign rd_data    = s.rd_data;

	assign auto_now  = (key_mode == DCR_KEY_AUTO);
	// Entering auto keying forces a fresh ramp period
	assign ramp_load = (commit & s.main_buf[`DCR_B_RAMP_LOAD])
		| (auto_now & ~s.auto_q);

	always_comb begin
		next_s = s;
		adv    = 1'b0;
		next_s.sync_in_q = sync_in;
		next_s.auto_q    = auto_now;

		// Buffered writes; unused bits never stored
		if (wr_en) begin
			case (wr_addr)
				`DCR_ADDR_MAIN: begin
					next_s.main_buf = wr_data & `DCR_MAIN_MASK;
				end
				`DCR_ADDR_ANALOG: begin
					next_s.ana_buf = wr_data[23:0] & `DCR_ANALOG_MASK;
				end
				`DCR_ADDR_ASF: begin
					next_s.asf_buf = wr_data[15:0];
				end
				`DCR_ADDR_ARR: begin
					next_s.arr_buf = wr_data[7:0];
				end
				`DCR_ADDR_FTW: begin
					next_s.ftw_buf = wr_data;
				end
				`DCR_ADDR_POW: begin
					next_s.pow_buf = wr_data[13:0] & `DCR_POW_MASK;
				end
				default: begin
				end
			endcase
		end

		// Divider and alignment; auto sync outranks the manual advances
		if (s.main_act[`DCR_B_AUTO_SYNC] && sync_rise) begin
			next_s.div = `DCR_SYNC_RISE;
			adv = 1'b1;
		end else if (s.ana_act[`DCR_B_HW_SYNC] && sync_rise) begin
			next_s.div = s.div + 2'h2;
			adv = 1'b1;
		end else if (s.main_act[`DCR_B_SOFT_SYNC]) begin
			next_s.div = `DCR_SYNC_RISE;
			adv = 1'b1;
		end else begin
			next_s.div = s.div + 2'h1;
		end
		// Self-clear; a commit in the same cycle wins below
		next_s.main_act[`DCR_B_SOFT_SYNC] = 1'b0;

		if (commit) begin
			next_s.main_act = s.main_buf;
			next_s.ana_act  = s.ana_buf;
			next_s.asf_act  = s.asf_buf;
			next_s.arr_act  = s.arr_buf;
			next_s.ftw_act  = s.ftw_buf;
			next_s.pow_act  = s.pow_buf;
			// Consumed request must not re-fire on the next commit
			if (!(wr_en && wr_addr == `DCR_ADDR_MAIN)) begin
				next_s.main_buf[`DCR_B_SOFT_SYNC] = 1'b0;
			end
		end

		// Datapath frozen in digital power-down
		if (!digital_pd) begin
			if (s.main_act[`DCR_B_CLR_ACC]) begin
				next_s.acc = 32'h0000_0000;
			end else if (commit && s.main_buf[`DCR_B_AUTO_CLR]) begin
				next_s.acc = 32'h0000_0000;
			end else begin
				next_s.acc = s.acc + s.ftw_act;
			end
			next_s.phase = s.acc[31:18] + s.pow_act;
			case (key_mode)
				DCR_KEY_OFF: begin
					next_s.amp = `DCR_FULL_SCALE;
				end
				DCR_KEY_MANUAL: begin
					next_s.amp = s.asf_act[13:0];
				end
				DCR_KEY_AUTO: begin
					next_s.amp = ramp_scale;
				end
				default: begin
					next_s.amp = `DCR_FULL_SCALE;
				end
			endcase
		end

		// Reads show committed state; unmapped reads zero
		case (rd_addr)
			`DCR_ADDR_MAIN: begin
				next_s.rd_data = s.main_act;
			end
			`DCR_ADDR_ANALOG: begin
				next_s.rd_data = {8'h00, s.ana_act};
			end
			`DCR_ADDR_ASF: begin
				next_s.rd_data = {16'h0000, s.asf_act};
			end
			`DCR_ADDR_ARR: begin
				next_s.rd_data = {24'h00_0000, s.arr_act};
			end
			`DCR_ADDR_FTW: begin
				next_s.rd_data = s.ftw_act;
			end
			`DCR_ADDR_POW: begin
				next_s.rd_data = {18'h0_0000, s.pow_act};
			end
			default: begin
				next_s.rd_data = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	dcr_ramp u_ramp (
		.clk       (clk),
		.rstn      (rstn),
		.run       (~digital_pd),
		.key_mode  (key_mode),
		.load_now  (ramp_load),
		.osk_pin   (keying_input_pin),
		.max_scale (s.asf_act[13:0]),
		.step_code (s.asf_act[15:14]),
		.rate      (s.arr_act),
		.scale     (ramp_scale)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_unused_zero: assert property ((s.main_act & ~`DCR_MAIN_MASK) == 32'h0)
		else $error("unused control bits held nonzero");
	a_accum_hold: assert property (
		s.main_act[`DCR_B_CLR_ACC] && !digital_pd |=> s.acc == 32'h0)
		else $error("accumulator not held at zero");
	a_autoclr_zero: assert property (
		commit && s.main_buf[`DCR_B_AUTO_CLR] && !digital_pd |=> s.acc == 32'h0)
		else $error("accumulator not cleared on commit");
	a_ftw_step: assert property (
		!digital_pd && !s.main_act[`DCR_B_CLR_ACC] && !commit
		|=> s.acc == $past(s.acc) + $past(s.ftw_act))
		else $error("accumulator did not add tuning word");
	a_soft_clear: assert property (
		s.main_act[`DCR_B_SOFT_SYNC] && !commit |=> !s.main_act[`DCR_B_SOFT_SYNC])
		else $error("soft sync bit did not self-clear");
	a_div_count: assert property (!adv |=> s.div == $past(s.div) + 2'h1)
		else $error("sync divider skipped without cause");
	a_commit_edge: assert property (
		io_update && !sync_edge |=> s.ftw_act == $past(s.ftw_act))
		else $error("registers committed off sync edge");
	a_manual_scale: assert property (
		key_mode == DCR_KEY_MANUAL && !digital_pd |=> s.amp == $past(s.asf_act[13:0]))
		else $error("manual scale not applied");
	a_sync_pin_low: assert property (
		s.main_act[`DCR_B_SYNC_OFF] |-> !sync_clk_out ##1 s.div != $past(s.div))
		else $error("sync clock pin not static or divider stopped");
	a_pd_full: assert property (
		power_down_pin && s.main_act[`DCR_B_FULL_PD] |-> dac_pd && pll_pd && clk_in_pd)
		else $error("full power-down not applied");

	c_commit: cover property (commit);
	c_soft_sync: cover property (s.main_act[`DCR_B_SOFT_SYNC] ##1 sync_edge);
	c_auto_sync: cover property (s.main_act[`DCR_B_AUTO_SYNC] && sync_rise);
	c_auto_key: cover property (key_mode == DCR_KEY_AUTO ##[1:50] s.amp != 14'h0000);

endmodule : dcr_bank

// ==== dcr_defs.svh ====
/*
 * Offsets, field positions, masks, reset values and timing figures of the
 * synthesizer control register bank.
 * Assumes it is included by bare name from each design file that needs it.
 */
// Functional notes
// - Ramp timer reloads on commit when bit26
// - Keying bypassed unless enable bit set
// - Manual keying scales output by amplitude register
// - Auto keying ramps scale with keying pin
// - Auto sync aligns sync clock to input
// - Soft sync advances one edge, self-clears; the code instead loads the divider with its rising count
// - Auto-clear zeroes accumulator on each commit
// - Bit12 selects sine, default cosine
// - Clear bit holds accumulator at zero
// - Bit9 selects three-wire input-only data pin
// - Bit8 selects least significant bit first
// - Digital power-down freezes all but serial port; the code freezes only accumulator, phase, amplitude and the keying ramp
// - Bits5 and 4 power down converter, clock
// - Bit3 widens power-down pin to everything
// - Bit1 holds sync clock pin low
// - Hardware sync advances one reference cycle per edge
// - Multiplier 4 to 20 valid, else bypass
// - Amplitude register step size and cap fields
// - Ramp rate register only matters in auto
// - Tuning word added to accumulator each cycle
// - Phase offset added to accumulator output
// - Commit strobe sampled on sync clock rise
// - Sync clock is sample clock divided four
// - Keying pin change reloads ramp timer
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

`define DCR_ADDR_MAIN       5'h00
`define DCR_ADDR_ANALOG     5'h01
`define DCR_ADDR_ASF        5'h02
`define DCR_ADDR_ARR        5'h03
`define DCR_ADDR_FTW        5'h04
`define DCR_ADDR_POW        5'h05

`define DCR_MAIN_MASK       32'h07c0_37ba
`define DCR_ANALOG_MASK     24'h00_0eff
`define DCR_POW_MASK        14'h3fff
`define DCR_MAIN_RESET      32'h0000_0000
`define DCR_ANALOG_RESET    24'h00_0000

`define DCR_B_RAMP_LOAD     26
`define DCR_B_KEY_EN        25
`define DCR_B_KEY_AUTO      24
`define DCR_B_AUTO_SYNC     23
`define DCR_B_SOFT_SYNC     22
`define DCR_B_AUTO_CLR      13
`define DCR_B_SINE          12
`define DCR_B_CLR_ACC       10
`define DCR_B_SDIO_IN       9
`define DCR_B_LSB_FIRST     8
`define DCR_B_DIG_PD        7
`define DCR_B_DAC_PD        5
`define DCR_B_CLKIN_PD      4
`define DCR_B_FULL_PD       3
`define DCR_B_SYNC_OFF      1

`define DCR_B_HS_SYNC       11
`define DCR_B_HW_SYNC       10
`define DCR_B_XTAL_OUT      9
`define DCR_B_VCO_HI        2

`define DCR_PLL_MIN         5'h04
`define DCR_PLL_MAX         5'h14
`define DCR_FULL_SCALE      14'h3fff

`define DCR_CLK_NS          10
`define DCR_SYNC_DIV        4
`define DCR_SYNC_RISE       2'h2

`endif

// ==== dcr_pkg.sv ====
/*
 * Types of the synthesizer control register bank.
 * Assumes the defs header supplies all numeric constants.
 */
package dcr_pkg;

	typedef enum logic [1:0] {
		DCR_KEY_OFF,
		DCR_KEY_MANUAL,
		DCR_KEY_AUTO
	} dcr_key_mode_t;

	typedef struct packed {
		logic [31:0] main_buf;
		logic [31:0] main_act;
		logic [23:0] ana_buf;
		logic [23:0] ana_act;
		logic [15:0] asf_buf;
		logic [15:0] asf_act;
		logic [7:0]  arr_buf;
		logic [7:0]  arr_act;
		logic [31:0] ftw_buf;
		logic [31:0] ftw_act;
		logic [13:0] pow_buf;
		logic [13:0] pow_act;
		logic [1:0]  div;
		logic [31:0] acc;
		logic [13:0] phase;
		logic [13:0] amp;
		logic        sync_in_q;
		logic        auto_q;
		logic [31:0] rd_data;
	} dcr_bank_state_t;

	typedef struct packed {
		logic [7:0]  timer;
		logic [13:0] scale;
		logic        osk_q;
	} dcr_ramp_state_t;

endpackage : dcr_pkg

// ==== dcr_ramp.sv ====
/*
 * Automatic amplitude keying ramp: reload timer plus saturating scale
 * counter.
 * Assumes pins synchronous to clk and a bank that supplies mode and loads.
 */
`timescale 1ns/10ps
`include "dcr_defs.svh"

module dcr_ramp (
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic                  run,
	input  wire dcr_pkg::dcr_key_mode_t key_mode,
	input  wire logic                  load_now,
	input  wire logic                  osk_pin,
	input  wire logic [13:0]           max_scale,
	input  wire logic [1:0]            step_code,
	input  wire logic [7:0]            rate,
	output logic      [13:0]           scale
);
	import dcr_pkg::*;

	dcr_ramp_state_t r;
	dcr_ramp_state_t next_r;
	logic            tick;
	logic            auto_on;
	logic [14:0]     step;
	logic [14:0]     up_sum;

	assign auto_on = (key_mode == DCR_KEY_AUTO);
	assign scale   = r.scale;

	always_comb begin
		next_r = r;
		tick   = 1'b0;
		step   = 15'h0001 << step_code;
		up_sum = {1'b0, r.scale} + step;
		next_r.osk_q = osk_pin;
		if (!auto_on) begin
			next_r.scale = 14'h0000;
			next_r.timer = rate;
		end else if (run) begin
			if (load_now || (osk_pin != r.osk_q)) begin
				next_r.timer = rate;
			end else if (r.timer <= 8'h01) begin
				next_r.timer = rate;
				tick = 1'b1;
			end else begin
				next_r.timer = r.timer - 8'h01;
			end
		end
		if (tick) begin
			if (r.osk_q) begin
				if (up_sum > {1'b0, max_scale}) begin
					next_r.scale = max_scale;
				end else begin
					next_r.scale = up_sum[13:0];
				end
			end else if ({1'b0, r.scale} > step) begin
				next_r.scale = r.scale - step[13:0];
			end else begin
				next_r.scale = 14'h0000;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_ramp_off_zero: assert property (!auto_on |=> r.scale == 14'h0000)
		else $error("ramp scale not zero outside auto keying");
	a_ramp_pin_reload: assert property (
		auto_on && run && (osk_pin != r.osk_q) |=> r.timer == $past(rate))
		else $error("ramp timer not reloaded on keying pin change");
	a_ramp_up_capped: assert property (
		auto_on && tick && r.osk_q && (r.scale <= max_scale) |=> r.scale <= $past(max_scale)
		&& r.scale >= $past(r.scale))
		else $error("ramp up exceeded cap or fell");
	c_ramp_at_max: cover property (auto_on && r.scale == max_scale && max_scale != 14'h0000);

endmodule : dcr_ramp

// ==== dcr_host_model.sv ====
/* Host model: hands whole register words to the bank and commits them.
   Assumes the defs header and a bench that calls put and commit. */
`timescale 1ns/10ps
`include "dcr_defs.svh"
module dcr_host_model (
	input  wire logic        clk,
	output logic             wr_en,
	output logic [4:0]       wr_addr,
	output logic [31:0]      wr_data,
	output logic             io_update
);
	logic [23:0] ana_shadow;
	initial begin
		wr_en = 1'b0;
		wr_addr = 5'h1f;
		wr_data = 32'h0;
		io_update = 1'b0;
		ana_shadow = 24'h0;
	end
	task put_word(input logic [4:0] a, input logic [31:0] d);
		repeat ($urandom_range(2)) @(negedge clk);
		@(negedge clk);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge clk);
		wr_en = 1'b0;
		// Released lines carry junk, not the last word
		wr_addr = ~a;
		wr_data = ~d;
	endtask : put_word
	// Raw skips the masking, for scenarios that break the host's side
	task put(input logic [4:0] a, input logic [31:0] d, input bit raw);
		logic [31:0] w;
		w = d;
		if (!raw) begin
			if (a == `DCR_ADDR_MAIN) w = d & `DCR_MAIN_MASK;
			if (a == `DCR_ADDR_ANALOG) w = d & {8'h0, `DCR_ANALOG_MASK};
			if (a == `DCR_ADDR_POW) w = d & {18'h0, `DCR_POW_MASK};
			if (a == `DCR_ADDR_ANALOG) ana_shadow = w[23:0];
			if (a == `DCR_ADDR_MAIN && d[`DCR_B_AUTO_SYNC]) begin
				ana_shadow[`DCR_B_HS_SYNC] = 1'b1;
				put_word(`DCR_ADDR_ANALOG, {8'h0, ana_shadow});
			end
		end
		put_word(a, w);
	endtask : put
	// Held over four edges so exactly one sync rise samples it
	task commit;
		@(negedge clk);
		io_update = 1'b1;
		repeat (4) @(negedge clk);
		io_update = 1'b0;
		repeat (3) @(negedge clk);
	endtask : commit
endmodule : dcr_host_model

// ==== dds_control_register_bank_bench.sv ====
/* Self-checking bench of the synthesizer control register bank.
   Assumes dcr_host_model as host and the defs header constants. */
`timescale 1ns/10ps
`include "dcr_defs.svh"
module dds_control_register_bank_bench;
	import dcr_pkg::*;
	typedef struct {
		logic [31:0] exp;
		int          sel;
	} dcr_note_t;
	logic          clk, rstn, wr_en, io_update, sync_in, keying_input_pin, power_down_pin;
	logic          sync_clk_out, sine_sel, digital_pd, dac_pd, clk_in_pd, pll_pd;
	logic          sdio_input_only, lsb_first, pll_bypass, vco_range, xtal_out_en, hs_sync_en;
	logic [1:0]    cp_current;
	logic [4:0]    wr_addr, rd_addr, pll_mult;
	logic [31:0]   wr_data, rd_data, v;
	logic [13:0]   phase_word, amp_scale, prev_phase, prev_amp;
	dcr_key_mode_t key_mode;
	int            k, s, fails = 0, n_compared = 0;
	int            bits[6] = '{12, 9, 8, 7, 5, 4};
	int            mults[6] = '{3, 4, 20, 21, 0, 31};
	dcr_note_t     notes[$];
	dcr_note_t     n;
	event          note_ev;

	dcr_host_model host (.clk, .wr_en, .wr_addr, .wr_data, .io_update);
	dcr_bank dut (
		.clk, .rstn, .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_data, .io_update, .sync_in,
		.keying_input_pin, .power_down_pin, .sync_clk_out, .phase_word, .sine_sel, .amp_scale,
		.key_mode, .digital_pd, .dac_pd, .clk_in_pd, .pll_pd, .sdio_input_only, .lsb_first,
		.pll_mult, .pll_bypass, .vco_range, .cp_current, .xtal_out_en, .hs_sync_en
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		prev_phase <= phase_word;
		prev_amp <= amp_scale;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task note(input logic [31:0] e, input int sel);
		notes.push_back('{e, sel});
		->note_ev;
	endtask : note
	task rd(input logic [4:0] a, input logic [31:0] e);
		@(negedge clk);
		rd_addr = a;
		@(negedge clk);
		note(e, 0);
	endtask : rd
	// Notes every amplitude step on the way, then the end level
	task ramp(input logic [13:0] goal, input logic [13:0] step);
		for (int c = 0; c < 1000 && amp_scale !== goal; c++) begin
			@(negedge clk);
			if (amp_scale !== prev_amp && amp_scale !== goal)
				note({18'h0, step}, 9);
		end
		note({18'h0, goal}, 1);
	endtask : ramp
	task report_and_stop;
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	initial forever begin
		@(note_ev);
		while (notes.size() > 0) begin
			n = notes.pop_front();
			case (n.sel)
			0: check(rd_data, n.exp);
			1: check({18'h0, amp_scale}, n.exp);
			2: check({18'h0, phase_word}, n.exp);
			3: check({31'h0, sync_clk_out}, n.exp);
			4: check({28'h0, digital_pd, dac_pd, clk_in_pd, pll_pd}, n.exp);
			5: check({29'h0, sdio_input_only, lsb_first, sine_sel}, n.exp);
			6: check({31'h0, pll_bypass}, n.exp);
			7: check({30'h0, key_mode}, n.exp);
			8: check({18'h0, phase_word - prev_phase}, n.exp);
			10: check({22'h0, hs_sync_en, xtal_out_en, pll_mult, vco_range, cp_current}, n.exp);
			default: check({18'h0, amp_scale - prev_amp}, n.exp);
			endcase
		end
	end

	initial begin
		repeat (50000) @(posedge clk);
		fails++;
		report_and_stop();
	end

	initial begin
		void'($urandom(31));
		rstn = 1'b0;
		rd_addr = 5'h0;
		sync_in = 1'b0;
		keying_input_pin = 1'b0;
		power_down_pin = 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		// Sync input pulses must not move the divider while alignment is off
		for (k = 1; k <= 8; k++) begin
			@(negedge clk);
			note({31'h0, k[1]}, 3);
			sync_in = k[0];
		end
		for (k = 0; k < 7; k++) rd(k[4:0], 32'h0);
		note(32'h0000_3fff, 1);
		note(DCR_KEY_OFF, 7);
		for (k = 0; k < 7; k++) host.put(k[4:0], 32'hffff_ffff, 1'b1);
		host.commit();
		repeat (4) begin
			@(negedge clk);
			note(32'h0, 3);
		end
		rd(`DCR_ADDR_MAIN, `DCR_MAIN_MASK & ~32'h0040_0000);
		rd(`DCR_ADDR_ANALOG, {8'h0, `DCR_ANALOG_MASK});
		rd(`DCR_ADDR_ASF, 32'h0000_ffff);
		rd(`DCR_ADDR_ARR, 32'h0000_00ff);
		rd(`DCR_ADDR_FTW, 32'hffff_ffff);
		rd(`DCR_ADDR_POW, {18'h0, `DCR_POW_MASK});
		rd(5'h06, 32'h0);
		for (k = 0; k < 6; k++) host.put(k[4:0], 32'h0, 1'b0);
		host.commit();
		foreach (bits[i]) begin
			host.put(`DCR_ADDR_MAIN, 32'h1 << bits[i], 1'b0);
			host.commit();
			note({29'h0, bits[i] == 9, bits[i] == 8, bits[i] == 12}, 5);
			note({28'h0, bits[i] == 7, bits[i] == 5, bits[i] == 4, 1'b0}, 4);
		end
		for (k = 0; k < 2; k++) begin
			host.put(`DCR_ADDR_MAIN, k << 3, 1'b0);
			host.commit();
			power_down_pin = 1'b1;
			@(negedge clk);
			note({28'h0, 1'b1, {3{k[0]}}}, 4);
			@(negedge clk);
			power_down_pin = 1'b0;
		end
		foreach (mults[i]) begin
			v = $urandom;
			host.put(`DCR_ADDR_ANALOG, {20'h0, v[1], 1'b0, v[0], 1'b0, mults[i][4:0], v[4:2]}, 1'b0);
			host.commit();
			note(mults[i] < 4 || mults[i] > 20, 6);
			note({22'h0, v[1], v[0], mults[i][4:0], v[4:2]}, 10);
		end
		v = $urandom;
		host.put(`DCR_ADDR_MAIN, 32'h0200_0000, 1'b0);
		host.put(`DCR_ADDR_ASF, v, 1'b0);
		host.put(`DCR_ADDR_ARR, $urandom, 1'b0);
		host.commit();
		note(v[13:0], 1);
		note(DCR_KEY_MANUAL, 7);
		for (s = 0; s < 4; s++) begin
			host.put(`DCR_ADDR_ASF, {16'h0, s[1:0], 14'h0040}, 1'b0);
			host.put(`DCR_ADDR_ARR, $urandom_range(5, 2), 1'b0);
			host.put(`DCR_ADDR_MAIN, 32'h0300_0000, 1'b0);
			host.commit();
			note(DCR_KEY_AUTO, 7);
			repeat (20) @(negedge clk);
			keying_input_pin = 1'b1;
			ramp(14'h0040, 14'h0001 << s);
			keying_input_pin = 1'b0;
			ramp(14'h0000, -(14'h0001 << s));
		end
		// One sync input rise realigns the divider to its rising count
		host.put(`DCR_ADDR_MAIN, 32'h0080_0000, 1'b0);
		host.commit();
		sync_in = 1'b1;
		for (k = 0; k < 5; k++) begin
			@(negedge clk);
			sync_in = 1'b0;
			note({31'h0, k < 2 || k == 4}, 3);
		end
		v = $urandom;
		host.put(`DCR_ADDR_FTW, {v[13:0], 18'h0}, 1'b0);
		host.put(`DCR_ADDR_POW, v[31:16], 1'b0);
		host.put(`DCR_ADDR_MAIN, 32'h0000_0400, 1'b0);
		host.commit();
		repeat (3) begin
			@(negedge clk);
			note(v[29:16], 2);
		end
		host.put(`DCR_ADDR_MAIN, 32'h0, 1'b0);
		host.commit();
		repeat (3) begin
			@(negedge clk);
			note(v[13:0], 8);
		end
		host.put(`DCR_ADDR_MAIN, 32'h0000_0080, 1'b0);
		host.commit();
		repeat (3) begin
			@(negedge clk);
			note(32'h0, 8);
		end
		// Leave power-down first: a frozen datapath ignores the auto-clear
		host.put(`DCR_ADDR_FTW, 32'h0, 1'b0);
		host.put(`DCR_ADDR_MAIN, 32'h0, 1'b0);
		host.commit();
		host.put(`DCR_ADDR_MAIN, 32'h0000_2000, 1'b0);
		host.commit();
		note(v[29:16], 2);
		repeat (2) @(negedge clk);
		report_and_stop();
	end
endmodule : dds_control_register_bank_bench
